// *** hw/pdmc_map.svh ***
// Register offsets, field positions, reset values and counts of the power mode controller
`ifndef PDMC_MAP_SVH
`define PDMC_MAP_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define PDMC_MODE_CTRL_OFS 8'h00
`define PDMC_DOMAIN_CFG_OFS 8'h04
`define PDMC_AON_CTRL_OFS 8'h08
`define PDMC_PWR_CTRL_OFS 8'h0C
`define PDMC_STATUS_OFS 8'h10
`define PDMC_IRQ_STAT_OFS 8'h14
`define PDMC_IRQ_MASK_OFS 8'h18
`define PDMC_RET_BASE_OFS 8'h40
`define PDMC_RET_WORDS 16
`define PDMC_RET_AW 4
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PDMC_CFG_TIM_EN 0
`define PDMC_CFG_RAD_EN 1
`define PDMC_CFG_RAM_LSB 2
`define PDMC_RAM_BANKS 3
`define PDMC_AON_POR_MASK 4
`define PDMC_PWR_LOW_OFF 0
`define PDMC_PWR_POR_DIS 1
`define PDMC_IRQ_WOKE 0
`define PDMC_IRQ_POR 1
`define PDMC_IRQ_BITS 2
`define PDMC_DOMAINS 5
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define PDMC_TRIM_RST 4'hE
`define PDMC_CFG_RST 5'h00
`define PDMC_WAKE_SYNC_TICKS 2'h3
`endif

// *** hw/pdmc_pkg.sv ***
// Types of the power mode controller
package pdmc_pkg;
   typedef enum logic [2:0] {
      PDMC_ACTIVE = 3'b000,
      PDMC_SLEEP = 3'b001,
      PDMC_EXT_SLEEP = 3'b010,
      PDMC_DEEP_SLEEP = 3'b011,
      PDMC_HIBERNATE = 3'b100,
      PDMC_WAKE_SYNC = 3'b101,
      PDMC_WAKE_REG = 3'b110
   } pdmc_mode_e;
   // Domain index order of the power and isolation vectors
   typedef enum logic [2:0] {
      PDMC_D_AON = 3'd0,
      PDMC_D_SLP = 3'd1,
      PDMC_D_SYS = 3'd2,
      PDMC_D_TIM = 3'd3,
      PDMC_D_RAD = 3'd4
   } pdmc_domain_e;
endpackage

// *** hw/pdmc_ret_mem.sv ***
// Always-on retention store for registers of switchable domains
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_map.svh"
module pdmc_ret_mem (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [`PDMC_RET_AW-1:0] wr_addr,
   input wire logic [31:0] wr_data,
   input wire logic rd_en,
   input wire logic [`PDMC_RET_AW-1:0] rd_addr,
   output logic [31:0] rd_data
);
   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // No reset: contents must survive any power mode, which is the point
   logic [31:0] mem_q [`PDMC_RET_WORDS];

   // Write port
   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
      begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge ref_clk)
   begin
      if (rd_en)
      begin
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule
`default_nettype wire

// *** hw/pdmc_top.sv ***
// Power domain and power mode controller with register port
// Summary of operation
// R1 - Always-on domain holding wake logic and pads is never switched off.
// R2 - Timer domain may stay powered through sleep modes when enabled.
// R3 - RAM retention is set apart from domain power state.
// R4 - Sleep: no gating, system domain on, timer and radio as programmed.
// R5 - Active and sleep: three domains on, core regulator active, all clocks.
// R6 - Extended sleep: system and radio off, regulator retain, RAM as programmed.
// R7 - Extended sleep uses slow clock only; wakes on alarm, capture or radio timer.
// R8 - Deep sleep: system and radio off, wakes on any pin, alarm or capture.
// R9 - Hibernation: clocks off, clamp feeds always-on domain, five pins wake.
// R10 - Software sets clamp trim before hibernation per temperature and RAM.
// R11 - Named controller registers keep their values while their domain is off.
// R12 - Writing one to the low regulator field turns that regulator off.
// R13 - Software masks battery-high reset below threshold and stops OTP reads.
// R14 - Masked battery-high detector stays readable but causes no reset.
// R15 - Disabled battery-high detector is off and its status reads zero.
// R16 - Hibernation wake waits three slow clock cycles before bandgap and fast clock.
// R17 - Outputs of powered-off domains are isolated to inactive levels.
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_map.svh"
module pdmc_top
   import pdmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic cpu_wfi,
   input wire logic [11:0] gpio_wake,
   input wire logic [4:0] hib_wake_pins,
   input wire logic rtc_alarm,
   input wire logic capture_evt,
   input wire logic radio_sleep_evt,
   input wire logic slow_clk_tick,
   input wire logic por_high_raw,
   output logic [`PDMC_DOMAINS-1:0] domain_pwr_en,
   output logic [`PDMC_DOMAINS-1:0] domain_iso_en,
   output logic [`PDMC_RAM_BANKS-1:0] ram_retain,
   output logic [`PDMC_RAM_BANKS-1:0] ram_pwr_en,
   output logic core_regulator_active,
   output logic core_regulator_retain,
   output logic clamp_en,
   output logic [3:0] clamp_voltage_trim,
   output logic low_power_regulator_off,
   output logic fast_clk_en,
   output logic slow_clk_only,
   output logic bandgap_en,
   output logic por_high_det_en,
   output logic por_high_reset,
   output logic irq
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   localparam int SYNC_W = 22;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [SYNC_W-1:0] async_in;
   assign async_in = {gpio_wake, hib_wake_pins, rtc_alarm, capture_evt, radio_sleep_evt,
                      slow_clk_tick, por_high_raw};

   // Two stages for every pin; only stage two feeds logic
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   logic [11:0] gpio_s;
   logic [4:0] hib_s;
   logic rtc_s;
   logic cap_s;
   logic rad_s;
   logic tick_s;
   logic por_s;
   assign {gpio_s, hib_s, rtc_s, cap_s, rad_s, tick_s, por_s} = sync2_q;

   // Slow tick edge, so each slow cycle counts once
   logic tick_d_q;
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_d_q <= 1'b0;
      end
      else
      begin
         tick_d_q <= tick_s;
      end
   end
   logic tick_rise;
   assign tick_rise = tick_s & ~tick_d_q;

   // ------------------------------------------------------------
   // Register port decode
   // ------------------------------------------------------------
   logic wr_mode;
   logic wr_cfg;
   logic wr_aon;
   logic wr_pwr;
   logic wr_mask;
   logic rd_irq;
   logic in_ret;
   assign wr_mode = reg_wr & (reg_addr == `PDMC_MODE_CTRL_OFS);
   assign wr_cfg = reg_wr & (reg_addr == `PDMC_DOMAIN_CFG_OFS);
   assign wr_aon = reg_wr & (reg_addr == `PDMC_AON_CTRL_OFS);
   assign wr_pwr = reg_wr & (reg_addr == `PDMC_PWR_CTRL_OFS);
   assign wr_mask = reg_wr & (reg_addr == `PDMC_IRQ_MASK_OFS);
   assign rd_irq = reg_rd & (reg_addr == `PDMC_IRQ_STAT_OFS);
   assign in_ret = (reg_addr[7:6] == 2'h1) & (reg_addr[1:0] == 2'h0);

   pdmc_mode_e state_q;
   pdmc_mode_e mode_req_q;
   logic [4:0] cfg_q;
   logic [3:0] trim_q;
   logic por_mask_q;
   logic low_off_q;
   logic por_dis_q;
   logic [`PDMC_IRQ_BITS-1:0] irq_stat_q;
   logic [`PDMC_IRQ_BITS-1:0] irq_mask_q;
   logic wake_done;

   // Requested sleep mode; hardware returns it to active on wake
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_req_q <= PDMC_ACTIVE;
      end
      else if (wr_mode && reg_wdata[2:0] <= 3'h4)
      begin
         mode_req_q <= pdmc_mode_e'(reg_wdata[2:0]);
      end
      else if (wake_done)
      begin
         mode_req_q <= PDMC_ACTIVE;
      end
   end

   // Domain enables and RAM retention, held apart from domain power [R3]
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_q <= `PDMC_CFG_RST;
      end
      else if (wr_cfg)
      begin
         cfg_q <= reg_wdata[4:0];
      end
   end

   // Always-on control: clamp trim and battery-high reset mask [R10]
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         trim_q <= `PDMC_TRIM_RST;
         por_mask_q <= 1'b0;
      end
      else if (wr_aon)
      begin
         trim_q <= reg_wdata[3:0];
         por_mask_q <= reg_wdata[`PDMC_AON_POR_MASK];
      end
   end

   // Power control: low regulator off and detector disable [R12]
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         low_off_q <= 1'b0;
         por_dis_q <= 1'b0;
      end
      else if (wr_pwr)
      begin
         low_off_q <= reg_wdata[`PDMC_PWR_LOW_OFF];
         por_dis_q <= reg_wdata[`PDMC_PWR_POR_DIS];
      end
   end

   // ------------------------------------------------------------
   // Mode sequencer
   // ------------------------------------------------------------
   logic [1:0] sync_cnt_q;
   logic wake_ev;
   always_comb
   begin
      case (state_q)
         PDMC_SLEEP: wake_ev = |gpio_s | rtc_s | cap_s | rad_s;
         PDMC_EXT_SLEEP: wake_ev = rtc_s | cap_s | rad_s; // [R7]
         PDMC_DEEP_SLEEP: wake_ev = |gpio_s | rtc_s | cap_s; // [R8]
         PDMC_HIBERNATE: wake_ev = |hib_s; // [R9]
         default: wake_ev = 1'b0;
      endcase
   end
   assign wake_done = (wake_ev & (state_q != PDMC_HIBERNATE)) | (state_q == PDMC_WAKE_REG);

   // Sleep is entered only once the processor idles
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= PDMC_ACTIVE;
      end
      else
      begin
         case (state_q)
            PDMC_ACTIVE:
            begin
               if (cpu_wfi && mode_req_q != PDMC_ACTIVE)
               begin
                  state_q <= mode_req_q;
               end
            end
            PDMC_SLEEP, PDMC_EXT_SLEEP, PDMC_DEEP_SLEEP:
            begin
               if (wake_ev)
               begin
                  state_q <= PDMC_ACTIVE;
               end
            end
            PDMC_HIBERNATE:
            begin
               if (wake_ev)
               begin
                  state_q <= PDMC_WAKE_SYNC;
               end
            end
            PDMC_WAKE_SYNC:
            begin
               if (tick_rise && sync_cnt_q == `PDMC_WAKE_SYNC_TICKS - 2'h1)
               begin
                  state_q <= PDMC_WAKE_REG; // [R16]
               end
            end
            PDMC_WAKE_REG: state_q <= PDMC_ACTIVE;
            default: state_q <= PDMC_ACTIVE;
         endcase
      end
   end

   // Slow cycles spent synchronising a hibernation wake
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sync_cnt_q <= 2'h0;
      end
      else if (state_q != PDMC_WAKE_SYNC)
      begin
         sync_cnt_q <= 2'h0;
      end
      else if (tick_rise)
      begin
         sync_cnt_q <= sync_cnt_q + 2'h1; // [R16]
      end
   end

   // ------------------------------------------------------------
   // Domain, regulator and clock steering
   // ------------------------------------------------------------
   logic run;
   logic low_sleep;
   logic clockless;
   logic [`PDMC_DOMAINS-1:0] want;
   assign run = (state_q == PDMC_ACTIVE) | (state_q == PDMC_SLEEP);
   assign low_sleep = (state_q == PDMC_EXT_SLEEP) | (state_q == PDMC_DEEP_SLEEP);
   assign clockless = (state_q == PDMC_HIBERNATE) | (state_q == PDMC_WAKE_SYNC);
   assign want[PDMC_D_AON] = 1'b1; // [R1]
   assign want[PDMC_D_SLP] = ~clockless; // [R5] [R9]
   assign want[PDMC_D_SYS] = run; // [R4] [R6] [R8]
   assign want[PDMC_D_TIM] = cfg_q[`PDMC_CFG_TIM_EN] & (run | low_sleep); // [R2]
   assign want[PDMC_D_RAD] = cfg_q[`PDMC_CFG_RAD_EN] & run; // [R4] [R6]

   // Isolate before removing power, release after restoring it
   genvar gi;
   generate
      for (gi = 0; gi < `PDMC_DOMAINS; gi++)
      begin : g_dom
         always_ff @(posedge ref_clk or negedge rst_b)
         begin
            if (!rst_b)
            begin
               domain_pwr_en[gi] <= 1'b1;
               domain_iso_en[gi] <= 1'b0;
            end
            else
            begin
               domain_iso_en[gi] <= ~(want[gi] & domain_pwr_en[gi]); // [R17]
               domain_pwr_en[gi] <= want[gi] | (domain_pwr_en[gi] & ~domain_iso_en[gi]);
            end
         end
      end
   endgenerate

   // Regulator, clock and RAM outputs registered for glitch-free steering
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         core_regulator_active <= 1'b1;
         core_regulator_retain <= 1'b0;
         clamp_en <= 1'b0;
         fast_clk_en <= 1'b1;
         slow_clk_only <= 1'b0;
         bandgap_en <= 1'b1;
         ram_pwr_en <= '1;
         ram_retain <= '0;
      end
      else
      begin
         core_regulator_active <= run | (state_q == PDMC_WAKE_REG); // [R5]
         core_regulator_retain <= low_sleep; // [R6]
         clamp_en <= clockless; // [R9]
         fast_clk_en <= run | (state_q == PDMC_WAKE_REG); // [R5] [R16]
         slow_clk_only <= low_sleep; // [R7]
         bandgap_en <= ~clockless; // [R16]
         ram_pwr_en <= run ? '1 : '0;
         ram_retain <= run ? '0 : cfg_q[`PDMC_CFG_RAM_LSB +: `PDMC_RAM_BANKS]; // [R3] [R6]
      end
   end

   assign clamp_voltage_trim = trim_q;
   assign low_power_regulator_off = low_off_q; // [R12]

   // ------------------------------------------------------------
   // Battery-high detector
   // ------------------------------------------------------------
   logic por_status;
   assign por_status = por_s & ~por_dis_q; // [R15]
   assign por_high_det_en = ~por_dis_q; // [R15]
   assign por_high_reset = por_status & ~por_mask_q; // [R14]

   // ------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------
   logic por_d_q;
   logic [`PDMC_IRQ_BITS-1:0] irq_set;
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         por_d_q <= 1'b0;
      end
      else
      begin
         por_d_q <= por_status;
      end
   end
   assign irq_set[`PDMC_IRQ_WOKE] = (state_q != PDMC_ACTIVE) & wake_done;
   assign irq_set[`PDMC_IRQ_POR] = por_status & ~por_d_q;

   // Read clears; an event in the same cycle survives the clear
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         irq_stat_q <= '0;
         irq_mask_q <= '0;
      end
      else
      begin
         irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | irq_set;
         if (wr_mask)
         begin
            irq_mask_q <= reg_wdata[`PDMC_IRQ_BITS-1:0];
         end
      end
   end
   assign irq = |(irq_stat_q & irq_mask_q);

   // ------------------------------------------------------------
   // Retention store and read-back
   // ------------------------------------------------------------
   logic [31:0] ret_rdata;
   logic ret_sel_q;
   logic [31:0] rdata_q;
   pdmc_ret_mem u_ret (
      .ref_clk(ref_clk),
      .wr_en(reg_wr & in_ret), // [R11]
      .wr_addr(reg_addr[`PDMC_RET_AW+1:2]),
      .wr_data(reg_wdata),
      .rd_en(reg_rd & in_ret),
      .rd_addr(reg_addr[`PDMC_RET_AW+1:2]),
      .rd_data(ret_rdata)
   );

   // Read data register; unmapped offsets answer zero
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_q <= '0;
         ret_sel_q <= 1'b0;
      end
      else
      begin
         ret_sel_q <= reg_rd & in_ret;
         rdata_q <= '0;
         if (reg_rd)
         begin
            case (reg_addr)
               `PDMC_MODE_CTRL_OFS: rdata_q <= {29'h0, mode_req_q};
               `PDMC_DOMAIN_CFG_OFS: rdata_q <= {27'h0, cfg_q};
               `PDMC_AON_CTRL_OFS: rdata_q <= {27'h0, por_mask_q, trim_q};
               `PDMC_PWR_CTRL_OFS: rdata_q <= {30'h0, por_dis_q, low_off_q};
               `PDMC_STATUS_OFS: rdata_q <= {23'h0, por_status, domain_pwr_en, state_q};
               `PDMC_IRQ_STAT_OFS: rdata_q <= {30'h0, irq_stat_q};
               `PDMC_IRQ_MASK_OFS: rdata_q <= {30'h0, irq_mask_q};
               default: rdata_q <= '0;
            endcase
         end
      end
   end
   assign reg_rdata = ret_sel_q ? ret_rdata : rdata_q;
endmodule
`default_nettype wire

// *** testbench/pdmc_properties.sv ***
// Concurrent checks on the ports of the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_map.svh"
module pdmc_properties (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic slow_clk_tick,
   input wire logic [`PDMC_DOMAINS-1:0] domain_pwr_en,
   input wire logic [`PDMC_DOMAINS-1:0] domain_iso_en,
   input wire logic core_regulator_active,
   input wire logic core_regulator_retain,
   input wire logic clamp_en,
   input wire logic low_power_regulator_off,
   input wire logic fast_clk_en,
   input wire logic slow_clk_only,
   input wire logic por_high_det_en,
   input wire logic por_high_reset
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Slow ticks counted while the fast clock is off
   // ----------------------------------------
   logic tick_prev_q;
   logic [2:0] ticks_q;
   // Saturating, so a long hibernation cannot wrap the count
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_prev_q <= 1'b0;
         ticks_q <= 3'h0;
      end
      else
      begin
         tick_prev_q <= slow_clk_tick;
         if (fast_clk_en)
            ticks_q <= 3'h0;
         else if (slow_clk_tick && !tick_prev_q && ticks_q != 3'h7)
            ticks_q <= ticks_q + 3'h1;
      end
   end
   // ----------------------------------------
   // Register port steps
   // ----------------------------------------
   sequence pwr_write_s;
      reg_wr && reg_addr == `PDMC_PWR_CTRL_OFS;
   endsequence
   sequence mask_write_s;
      reg_wr && reg_addr == `PDMC_AON_CTRL_OFS && reg_wdata[`PDMC_AON_POR_MASK];
   endsequence
   sequence gap_read_s;
      reg_rd && reg_addr == 8'h20;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   aon_never_off_a: assert property (domain_pwr_en[0])
      else $error("always-on domain lost power");
   off_isolated_a: assert property ((~domain_pwr_en & ~domain_iso_en) == '0)
      else $error("unpowered domain not isolated");
   low_off_a: assert property (pwr_write_s |=>
      low_power_regulator_off == $past(reg_wdata[`PDMC_PWR_LOW_OFF]))
      else $error("low regulator field not applied");
   det_off_a: assert property (pwr_write_s |=>
      por_high_det_en == !$past(reg_wdata[`PDMC_PWR_POR_DIS]))
      else $error("detector enable not applied");
   masked_quiet_a: assert property (mask_write_s |=> !por_high_reset [*2])
      else $error("masked detector still resets");
   disabled_quiet_a: assert property (!por_high_det_en |-> !por_high_reset)
      else $error("disabled detector still resets");
   retain_slow_a: assert property (core_regulator_retain |->
      slow_clk_only && !fast_clk_en && !core_regulator_active)
      else $error("retain mode with fast clock");
   active_clocks_a: assert property (core_regulator_active |-> fast_clk_en && !slow_clk_only)
      else $error("active regulator without fast clock");
   clamp_core_off_a: assert property (clamp_en && !fast_clk_en |->
      !core_regulator_active && !core_regulator_retain)
      else $error("core regulator on in hibernation");
   // Only a wake out of the clamp-fed state needs the slow-cycle wait
   wake_sync_a: assert property ($rose(fast_clk_en) && $past(clamp_en) |-> ticks_q >= 3'h3)
      else $error("fast clock before three slow ticks");
   gap_zero_a: assert property (gap_read_s |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench of the power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_map.svh"
module testbench;
   import pdmc_pkg::*;
   logic ref_clk, rst_b, reg_wr, reg_rd, cpu_wfi, rtc_alarm, capture_evt, radio_sleep_evt;
   logic slow_clk_tick, por_high_raw, core_regulator_active, core_regulator_retain, clamp_en;
   logic low_power_regulator_off, fast_clk_en, slow_clk_only, bandgap_en, por_high_det_en;
   logic por_high_reset, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [11:0] gpio_wake;
   logic [4:0] hib_wake_pins, domain_pwr_en, domain_iso_en;
   logic [2:0] ram_retain, ram_pwr_en;
   logic [3:0] clamp_voltage_trim;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   pdmc_top i_dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cpu_wfi, .gpio_wake, .hib_wake_pins, .rtc_alarm, .capture_evt, .radio_sleep_evt,
      .slow_clk_tick, .por_high_raw, .domain_pwr_en, .domain_iso_en, .ram_retain,
      .ram_pwr_en, .core_regulator_active, .core_regulator_retain, .clamp_en,
      .clamp_voltage_trim, .low_power_regulator_off, .fast_clk_en, .slow_clk_only,
      .bandgap_en, .por_high_det_en, .por_high_reset, .irq);
   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // Ceiling is about a hundred times the length of the whole sequence
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic go(input logic [31:0] m);
      wr(`PDMC_MODE_CTRL_OFS, m);
      @(posedge ref_clk);
      cpu_wfi <= 1'b1;
      @(posedge ref_clk);
      cpu_wfi <= 1'b0;
      cyc(5);
   endtask
   // Slow ticks are long enough to pass the two-stage synchroniser
   task automatic tick();
      @(posedge ref_clk);
      slow_clk_tick <= 1'b1;
      repeat (3) @(posedge ref_clk);
      slow_clk_tick <= 1'b0;
      cyc(3);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst_b, reg_wr, reg_rd, cpu_wfi, rtc_alarm, capture_evt, radio_sleep_evt} = '0;
      {slow_clk_tick, por_high_raw, reg_addr, reg_wdata, gpio_wake, hib_wake_pins} = '0;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      cyc(1);
      chk(32'(domain_pwr_en), 32'h1F);
      // Timer and radio enables reset to off, so both domains isolate at once
      chk(32'({domain_iso_en, fast_clk_en, core_regulator_active, irq}), 32'hC6);
      rd(`PDMC_AON_CTRL_OFS, 32'hE);
      wr(8'h20, 32'hFFFFFFFF);
      rd(8'h20, 32'h0);
      wr(`PDMC_MODE_CTRL_OFS, 32'h7);
      rd(`PDMC_MODE_CTRL_OFS, 32'h0);
      wr(`PDMC_IRQ_MASK_OFS, 32'h1);
      wr(`PDMC_DOMAIN_CFG_OFS, 32'h19);
      rd(`PDMC_DOMAIN_CFG_OFS, 32'h19);
      wr(8'h44, 32'hA5C30F1E);
      rd(8'h44, 32'hA5C30F1E);
      // Deep sleep: radio timer refused, any pin wakes
      go(3);
      chk(32'({domain_pwr_en, domain_iso_en}), 32'h174);
      chk(32'({ram_retain, ram_pwr_en, core_regulator_retain, slow_clk_only}), 32'hC3);
      rd(`PDMC_STATUS_OFS, 32'h5B);
      radio_sleep_evt <= 1'b1;
      cyc(8);
      chk(32'(domain_pwr_en), 32'h0B);
      radio_sleep_evt <= 1'b0;
      gpio_wake <= 12'h020;
      cyc(8);
      gpio_wake <= 12'h000;
      chk(32'({domain_pwr_en, domain_iso_en, irq}), 32'h3E1);
      rd(`PDMC_MODE_CTRL_OFS, 32'h0);
      rd(`PDMC_IRQ_STAT_OFS, 32'h1);
      chk(32'(irq), 32'h0);
      // Extended sleep: pins refused, alarm wakes
      go(2);
      chk(32'({domain_pwr_en, slow_clk_only}), 32'h17);
      gpio_wake <= 12'hFFF;
      cyc(8);
      chk(32'(domain_pwr_en), 32'h0B);
      gpio_wake <= 12'h000;
      rtc_alarm <= 1'b1;
      cyc(8);
      rtc_alarm <= 1'b0;
      chk(32'(domain_pwr_en), 32'h0F);
      rd(`PDMC_IRQ_STAT_OFS, 32'h1);
      // Sleep keeps the system domain, capture wakes
      go(1);
      chk(32'({domain_pwr_en, core_regulator_active, fast_clk_en}), 32'h3F);
      rd(`PDMC_STATUS_OFS, 32'h79);
      capture_evt <= 1'b1;
      cyc(8);
      capture_evt <= 1'b0;
      rd(`PDMC_STATUS_OFS, 32'h78);
      rd(`PDMC_IRQ_STAT_OFS, 32'h1);
      // Hibernation: only designated pins, then three slow ticks
      wr(`PDMC_AON_CTRL_OFS, 32'hA);
      go(4);
      chk(32'({domain_pwr_en, clamp_en, fast_clk_en, clamp_voltage_trim}), 32'h6A);
      gpio_wake <= 12'hFFF;
      rtc_alarm <= 1'b1;
      cyc(8);
      chk(32'(domain_pwr_en), 32'h01);
      {gpio_wake, rtc_alarm} <= '0;
      hib_wake_pins <= 5'h01;
      cyc(4);
      tick();
      tick();
      cyc(4);
      chk(32'(fast_clk_en), 32'h0);
      tick();
      cyc(6);
      chk(32'({fast_clk_en, bandgap_en}), 32'h3);
      hib_wake_pins <= 5'h00;
      cyc(4);
      chk(32'(domain_pwr_en), 32'h0F);
      rd(`PDMC_IRQ_STAT_OFS, 32'h1);
      // Low regulator and battery-high detector
      wr(`PDMC_PWR_CTRL_OFS, 32'h1);
      cyc(1);
      chk(32'(low_power_regulator_off), 32'h1);
      por_high_raw <= 1'b1;
      cyc(4);
      chk(32'({por_high_reset, irq}), 32'h2);
      wr(`PDMC_IRQ_MASK_OFS, 32'h3);
      cyc(1);
      chk(32'(irq), 32'h1);
      wr(`PDMC_AON_CTRL_OFS, 32'h1A);
      cyc(1);
      chk(32'(por_high_reset), 32'h0);
      rd(`PDMC_STATUS_OFS, 32'h178);
      wr(`PDMC_PWR_CTRL_OFS, 32'h3);
      cyc(1);
      chk(32'({por_high_det_en, por_high_reset}), 32'h0);
      rd(`PDMC_STATUS_OFS, 32'h78);
      rd(`PDMC_IRQ_STAT_OFS, 32'h2);
      chk(32'(irq), 32'h0);
      print_verdict();
   end
endmodule
bind pdmc_top pdmc_properties i_props (.ref_clk(ref_clk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .slow_clk_tick(slow_clk_tick), .domain_pwr_en(domain_pwr_en),
   .domain_iso_en(domain_iso_en), .core_regulator_active(core_regulator_active),
   .core_regulator_retain(core_regulator_retain), .clamp_en(clamp_en),
   .low_power_regulator_off(low_power_regulator_off), .fast_clk_en(fast_clk_en),
   .slow_clk_only(slow_clk_only), .por_high_det_en(por_high_det_en),
   .por_high_reset(por_high_reset));
`default_nettype wire
